// ### hdl/cfd_comb_demod.v
// Adaptive line comb, vertical peaking and quadrature chroma demodulator with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "cfd_map.vh"

module cfd_fifo #(
    parameter W = 17,
    parameter D = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    // Occupancy
    output wire [AW:0] level
);
    reg [W-1:0] mem_ff [0:D-1];
    reg [AW-1:0] wp_ff;
    reg [AW-1:0] rp_ff;
    reg [AW:0] cnt_ff;
    wire push;
    wire pop;

    assign in_ready = (cnt_ff != D[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rp_ff];
    assign level = cnt_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys)
    begin
        if (push)
            mem_ff[wp_ff] <= in_data;
        if (!reset_n)
        begin
            wp_ff <= {AW{1'b0}};
            rp_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_ff <= (wp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
            if (pop)
                rp_ff <= (rp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule

// Contract
// - Four line delays feed three comb lines for PAL/NTSC composite separation.
// - Subcarrier increment is fractional to the fixed system clock, phase free running across lines.
// - Adaption weights soft-mix four bandpass/notch signals into luma and chroma.
// - Middle line is reference, so separation latency is two lines plus a few pipeline cycles.
// - Comb off still routes ADC luma and chroma through the delays, two lines.
// - Higher horizontal edge gain means stronger combing.
// - Higher vertical edge gain means weaker combing on vertical edges.
// - Higher diagonal reduction weakens combing where upper and lower lines disagree.
// - Vertical peaking gain 0 to +6 dB with coring of small detail.
// - Decoder always takes separated luma and chroma, S-VHS style.
// - Output is 4:2:2 luma with alternating Cb and Cr.
// - IF compensation: flat, 6 dB/oct, 12 dB/oct or 10 dB/MHz style boost.
// - PAL/NTSC chroma is quadrature mixed with the programmed subcarrier.
// - SECAM mixing uses a fixed 4.286 MHz carrier.
// - Lowpass after the mixer, then Cb/Cr multiplexed at half rate each.
// - Subcarrier comes from a phase accumulator, any frequency selectable except in SECAM mode.
// - Demodulator runs free on the system clock, same path for all standards.
module cfd_comb_demod (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // ADC samples, from the analog clock domain
    input wire [7:0] adc_luma,
    input wire [7:0] adc_chroma,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // 4:2:2 output stream
    output reg out_valid_ff,
    input wire out_ready,
    output reg [7:0] out_y_ff,
    output reg [7:0] out_c_ff,
    output reg out_is_cr_ff
);
    localparam integer LINE_LEN = `CFD_LINE_NS / `CFD_CLK_NS;
    localparam [63:0] SEC_INC64 = (`CFD_SECAM_HZ << 32) / `CFD_FS_HZ;
    localparam [63:0] PAL_INC64 = (`CFD_PAL_SC_HZ << 32) / `CFD_FS_HZ;
    localparam [31:0] SEC_INC = SEC_INC64[31:0];
    localparam [31:0] PAL_INC = PAL_INC64[31:0];
    localparam [10:0] LINE_LAST = LINE_LEN[10:0] - 11'd1;

    function signed [9:0] ctr;
        input [7:0] x;
        ctr = $signed({2'b00, x}) - 10'sd128;
    endfunction

    function [10:0] mag;
        input signed [10:0] v;
        mag = v[10] ? -v : v;
    endfunction

    function [7:0] sat_u8;
        input signed [13:0] v;
        if (v < 14'sd0)
            sat_u8 = 8'h00;
        else if (v > 14'sd255)
            sat_u8 = 8'hff;
        else
            sat_u8 = v[7:0];
    endfunction

    function [7:0] sat_s8;
        input signed [13:0] v;
        if (v < -14'sd128)
            sat_s8 = 8'h80;
        else if (v > 14'sd127)
            sat_s8 = 8'h7f;
        else
            sat_s8 = v[7:0];
    endfunction

    function signed [7:0] cos_lut;
        input [3:0] k;
        case (k)
            4'h0: cos_lut = 8'h7f;
            4'h1: cos_lut = 8'h75;
            4'h2: cos_lut = 8'h5a;
            4'h3: cos_lut = 8'h31;
            4'h4: cos_lut = 8'h00;
            4'h5: cos_lut = 8'hcf;
            4'h6: cos_lut = 8'ha6;
            4'h7: cos_lut = 8'h8b;
            4'h8: cos_lut = 8'h81;
            4'h9: cos_lut = 8'h8b;
            4'ha: cos_lut = 8'ha6;
            4'hb: cos_lut = 8'hcf;
            4'hc: cos_lut = 8'h00;
            4'hd: cos_lut = 8'h31;
            4'he: cos_lut = 8'h5a;
            default: cos_lut = 8'h75;
        endcase
    endfunction

    // Registers
    reg [`CFD_CTRL_W-1:0] ctrl_ff;
    reg [`CFD_GAIN_W-1:0] gain_ff;
    reg [31:0] scinc_ff;
    reg ovf_ff;
    wire comb_en = ctrl_ff[`CFD_CTRL_COMB];
    wire [1:0] ifc_sel = ctrl_ff[`CFD_CTRL_IFC_HI:`CFD_CTRL_IFC_LO];
    wire secam = ctrl_ff[`CFD_CTRL_SECAM];
    wire [3:0] horizontal_edge_gain = gain_ff[`CFD_GAIN_HG_HI:`CFD_GAIN_HG_LO];
    wire [3:0] vertical_edge_gain = gain_ff[`CFD_GAIN_VG_HI:`CFD_GAIN_VG_LO];
    wire [3:0] diag_red = gain_ff[`CFD_GAIN_DDR_HI:`CFD_GAIN_DDR_LO];
    wire [3:0] pk_raw = gain_ff[`CFD_GAIN_PK_HI:`CFD_GAIN_PK_LO];
    wire [7:0] coring = gain_ff[`CFD_GAIN_COR_HI:`CFD_GAIN_COR_LO];
    wire [3:0] pk = (pk_raw > `CFD_PEAK_MAX) ? `CFD_PEAK_MAX : pk_raw;
    // Clamped on write so software reads back the gain actually applied
    wire [3:0] pk_wr = (pwdata[`CFD_GAIN_PK_HI:`CFD_GAIN_PK_LO] > `CFD_PEAK_MAX) ?
        `CFD_PEAK_MAX : pwdata[`CFD_GAIN_PK_HI:`CFD_GAIN_PK_LO];

    // Pin synchronisers
    reg [7:0] lu_s1_ff;
    reg [7:0] lu_s2_ff;
    reg [7:0] ch_s1_ff;
    reg [7:0] ch_s2_ff;
    always @(posedge clk_sys)
    begin
        lu_s1_ff <= adc_luma;
        lu_s2_ff <= lu_s1_ff;
        ch_s1_ff <= adc_chroma;
        ch_s2_ff <= ch_s1_ff;
    end

    // Line delays; one write pointer shared by all four
    reg [10:0] wp_ff;
    always @(posedge clk_sys)
    begin
        if (!reset_n)
            wp_ff <= 11'h000;
        else
            wp_ff <= (wp_ff == LINE_LAST) ? 11'h000 : wp_ff + 11'h001;
    end

    wire [31:0] dly_in;
    wire [31:0] dly_q;
    // Comb on: one serial chain of composite; off: luma in 0-1, chroma in 2-3
    assign dly_in[7:0] = lu_s2_ff;
    assign dly_in[15:8] = dly_q[7:0];
    assign dly_in[23:16] = comb_en ? dly_q[15:8] : ch_s2_ff;
    assign dly_in[31:24] = dly_q[23:16];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_line
            reg [7:0] mem_ff [0:LINE_LEN-1];
            reg [7:0] q_ff;
            // Read before write gives a full line of delay per stage
            always @(posedge clk_sys)
            begin
                q_ff <= mem_ff[wp_ff];
                mem_ff[wp_ff] <= dly_in[gi*8+7:gi*8];
            end
            assign dly_q[gi*8+7:gi*8] = q_ff;
        end
    endgenerate

    // Three comb lines: newest, two lines back (reference), four back
    wire signed [9:0] t0 = ctr(lu_s2_ff);
    wire signed [9:0] m0 = ctr(dly_q[15:8]);
    wire signed [9:0] b0 = ctr(dly_q[31:24]);
    reg signed [9:0] t1_ff, t2_ff, m1_ff, m2_ff, b1_ff, b2_ff;
    always @(posedge clk_sys)
    begin
        t1_ff <= t0;
        t2_ff <= t1_ff;
        m1_ff <= m0;
        m2_ff <= m1_ff;
        b1_ff <= b0;
        b2_ff <= b1_ff;
    end

    // Subcarrier bandpass on each line and notch on the reference line
    // Concatenations are unsigned, so each is cast before the arithmetic shift
    wire signed [10:0] bp_t = $signed({t0[9], t0} - {t2_ff[9], t2_ff}) >>> 1;
    wire signed [10:0] bp_m = $signed({m0[9], m0} - {m2_ff[9], m2_ff}) >>> 1;
    wire signed [10:0] bp_b = $signed({b0[9], b0} - {b2_ff[9], b2_ff}) >>> 1;
    wire signed [10:0] notch_m = {m1_ff[9], m1_ff} - bp_m;

    // Chroma alternates in phase between comb lines, so a sum measures mismatch
    wire [10:0] e_up = mag(bp_m + bp_t);
    wire [10:0] e_dn = mag(bp_m + bp_b);
    wire [10:0] e_dg = (e_up > e_dn) ? e_up - e_dn : e_dn - e_up;
    wire [15:0] v_pen = (vertical_edge_gain * ({5'h00, e_up} + {5'h00, e_dn})) >> 5;
    wire [15:0] d_pen = (diag_red * {5'h00, e_dg}) >> 5;
    wire signed [17:0] w_raw = 18'sd8 + $signed({14'h0, horizontal_edge_gain})
        - $signed({2'b00, v_pen}) - $signed({2'b00, d_pen});
    wire [4:0] wc = (w_raw < 18'sd0) ? 5'd0 :
        (w_raw > 18'sd16) ? 5'd16 : w_raw[4:0];
    wire signed [11:0] c_avg = ($signed({bp_m[10], bp_m}) - ($signed({bp_t[10], bp_t} +
        {bp_b[10], bp_b}) >>> 1)) >>> 1;
    // Weighted blend avoids visible switching between comb and notch
    wire signed [17:0] c_mix = ($signed({1'b0, wc}) * c_avg
        + $signed({1'b0, 5'd16 - wc}) * bp_m) >>> 4;
    wire signed [11:0] y_mix = {notch_m[10], notch_m} + {bp_m[10], bp_m}
        - c_mix[11:0];

    // Vertical peaking on the reference line with coring
    wire signed [11:0] vdet = $signed({m1_ff[9], m1_ff, 1'b0} - {{2{t1_ff[9]}}, t1_ff}
        - {{2{b1_ff[9]}}, b1_ff}) >>> 2;
    wire [10:0] vdet_mag = mag(vdet[10:0]);
    wire signed [11:0] vcor = (vdet_mag <= {3'h0, coring}) ? 12'sd0 : vdet;
    wire signed [16:0] vboost = ($signed({1'b0, pk}) * vcor) >>> 3;

    // Separated pair handed to the decoder
    reg [7:0] sep_y_ff;
    reg signed [9:0] sep_c_ff;
    reg [4:0] wc_ff;
    wire signed [13:0] y_pk = {{2{y_mix[11]}}, y_mix} + vboost[13:0] + 14'sd128;
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sep_y_ff <= 8'h00;
            sep_c_ff <= 10'sd0;
            wc_ff <= 5'h00;
        end
        else if (comb_en)
        begin
            sep_y_ff <= sat_u8(y_pk);
            sep_c_ff <= c_mix[9:0];
            wc_ff <= wc;
        end
        else
        begin
            // Peaking needs combed neighbours, so it is bypassed here
            sep_y_ff <= dly_q[15:8];
            sep_c_ff <= ctr(dly_q[31:24]);
            wc_ff <= 5'h00;
        end
    end

    // IF compensation on the decoder chroma input
    reg signed [9:0] cz_ff;
    reg signed [11:0] cif_ff;
    wire signed [11:0] c_in = {{2{sep_c_ff[9]}}, sep_c_ff};
    wire signed [11:0] boost = c_in - {{2{cz_ff[9]}}, cz_ff};
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cz_ff <= 10'sd0;
            cif_ff <= 12'sd0;
        end
        else
        begin
            cz_ff <= sep_c_ff;
            case (ifc_sel)
                2'd0: cif_ff <= c_in;
                2'd1: cif_ff <= c_in + (boost >>> 1);
                2'd2: cif_ff <= c_in + boost;
                default: cif_ff <= c_in + boost + (boost <<< 1);
            endcase
        end
    end

    // Direct digital synthesis, free running on the system clock
    reg [31:0] ph_ff;
    wire [31:0] inc = secam ? SEC_INC : scinc_ff;
    always @(posedge clk_sys)
    begin
        if (!reset_n)
            ph_ff <= 32'h00000000;
        else
            ph_ff <= ph_ff + inc;
    end
    wire signed [7:0] lo_cos = cos_lut(ph_ff[31:28]);
    wire signed [7:0] lo_sin = cos_lut(ph_ff[31:28] - 4'h4);

    // Quadrature mixer, two-tap lowpass, Cb/Cr time multiplex
    wire signed [19:0] mix_u = (cif_ff * lo_cos) >>> 7;
    wire signed [19:0] mix_v = (cif_ff * lo_sin) >>> 7;
    reg signed [11:0] u1_ff, v1_ff;
    reg half_ff;
    reg [7:0] cmux_ff;
    reg [7:0] ydec_ff;
    reg is_cr_ff;
    wire signed [13:0] lp_u = $signed({{2{mix_u[11]}}, mix_u[11:0]}
        + {{2{u1_ff[11]}}, u1_ff}) >>> 1;
    wire signed [13:0] lp_v = $signed({{2{mix_v[11]}}, mix_v[11:0]}
        + {{2{v1_ff[11]}}, v1_ff}) >>> 1;
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            u1_ff <= 12'sd0;
            v1_ff <= 12'sd0;
            half_ff <= 1'b0;
            cmux_ff <= 8'h00;
            ydec_ff <= 8'h00;
            is_cr_ff <= 1'b0;
        end
        else
        begin
            u1_ff <= mix_u[11:0];
            v1_ff <= mix_v[11:0];
            half_ff <= ~half_ff;
            // Each difference signal is taken every other sample
            cmux_ff <= half_ff ? sat_s8(lp_v) : sat_s8(lp_u);
            is_cr_ff <= half_ff;
            ydec_ff <= sep_y_ff;
        end
    end

    // Output buffering; a full FIFO drops the sample and flags overflow
    wire f_in_ready;
    wire f_out_valid;
    wire f_out_ready = !out_valid_ff || out_ready;
    wire [16:0] f_out_data;
    wire [2:0] f_level;
    cfd_fifo #(
        .W(17),
        .D(4),
        .AW(2)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(reset_n),
        .in_ready(f_in_ready),
        .in_data({is_cr_ff, ydec_ff, cmux_ff}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data),
        .level(f_level)
    );
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            out_valid_ff <= 1'b0;
            out_y_ff <= 8'h00;
            out_c_ff <= 8'h00;
            out_is_cr_ff <= 1'b0;
        end
        else if (f_out_ready)
        begin
            out_valid_ff <= f_out_valid;
            out_is_cr_ff <= f_out_data[16];
            out_y_ff <= f_out_data[15:8];
            out_c_ff <= f_out_data[7:0];
        end
    end

    // APB slave: one wait-free access phase, answer registered at setup
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready_ff && pwrite;
    wire mapped = (paddr == `CFD_REG_CTRL) || (paddr == `CFD_REG_GAIN)
        || (paddr == `CFD_REG_SCINC) || (paddr == `CFD_REG_STAT);
    reg [31:0] rd_mux;
    always @*
    begin
        case (paddr)
            `CFD_REG_CTRL: rd_mux = {28'h0000000, ctrl_ff};
            `CFD_REG_GAIN: rd_mux = {8'h00, gain_ff};
            `CFD_REG_SCINC: rd_mux = scinc_ff;
            `CFD_REG_STAT: rd_mux = {19'h00000, wc_ff, 4'h0, f_level, ovf_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end
    wire ovf_set = !f_in_ready;
    wire ovf_clr = wr_en && (paddr == `CFD_REG_STAT) && pwdata[`CFD_STAT_OVF];
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            ctrl_ff <= `CFD_CTRL_RST;
            gain_ff <= `CFD_GAIN_RST;
            scinc_ff <= PAL_INC;
            ovf_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= setup;
            if (setup)
            begin
                pslverr_ff <= !mapped;
                prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
            end
            if (wr_en && paddr == `CFD_REG_CTRL)
                ctrl_ff <= pwdata[`CFD_CTRL_W-1:0];
            if (wr_en && paddr == `CFD_REG_GAIN)
                gain_ff <= {pwdata[`CFD_GAIN_COR_HI:`CFD_GAIN_COR_LO], pk_wr,
                    pwdata[`CFD_GAIN_DDR_HI:`CFD_GAIN_HG_LO]};
            if (wr_en && paddr == `CFD_REG_SCINC)
                scinc_ff <= pwdata;
            // A new overflow in the clearing cycle keeps the flag set
            if (ovf_set)
                ovf_ff <= 1'b1;
            else if (ovf_clr)
                ovf_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/cfd_map.vh
// Register map, field positions, reset values and timing constants of the comb demodulator
`ifndef CFD_MAP_VH
`define CFD_MAP_VH
`define CFD_REG_CTRL 8'h00
`define CFD_REG_GAIN 8'h04
`define CFD_REG_SCINC 8'h08
`define CFD_REG_STAT 8'h0c
`define CFD_CTRL_COMB 0
`define CFD_CTRL_IFC_LO 1
`define CFD_CTRL_IFC_HI 2
`define CFD_CTRL_SECAM 3
`define CFD_CTRL_W 4
`define CFD_CTRL_RST 4'h1
`define CFD_GAIN_HG_LO 0
`define CFD_GAIN_HG_HI 3
`define CFD_GAIN_VG_LO 4
`define CFD_GAIN_VG_HI 7
`define CFD_GAIN_DDR_LO 8
`define CFD_GAIN_DDR_HI 11
`define CFD_GAIN_PK_LO 12
`define CFD_GAIN_PK_HI 15
`define CFD_GAIN_COR_LO 16
`define CFD_GAIN_COR_HI 23
`define CFD_GAIN_W 24
`define CFD_GAIN_RST 24'h040444
`define CFD_STAT_OVF 0
`define CFD_FS_HZ 64'd20250000
`define CFD_PAL_SC_HZ 64'd4433619
`define CFD_SECAM_HZ 64'd4286000
`define CFD_LINE_NS 64000
`define CFD_CLK_NS 50
`define CFD_PEAK_MAX 4'h8
`endif

// ### dv/cfd_comb_demod_props.sv
// Port-level checker for the comb demodulator, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module cfd_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // ADC samples
    input wire logic [7:0] adc_luma,
    input wire logic [7:0] adc_chroma,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_ff,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    // Output stream
    input wire logic out_valid_ff,
    input wire logic out_ready,
    input wire logic [7:0] out_y_ff,
    input wire logic [7:0] out_c_ff,
    input wire logic out_is_cr_ff
);
    wire setup = psel && !penable;
    wire mapped = (paddr == 8'h00) || (paddr == 8'h04) || (paddr == 8'h08) || (paddr == 8'h0c);

    setup_ready_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup |=> pready_ff && penable) else $error("no ready one cycle after setup");
    ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pready_ff |=> !pready_ff) else $error("ready longer than one cycle");
    unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && !mapped |=> pslverr_ff && prdata_ff == 32'h0) else $error("unmapped not refused");
    mapped_ok_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && mapped |=> !pslverr_ff) else $error("mapped access refused");
    write_rdata_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && pwrite |=> prdata_ff == 32'h0) else $error("write returned data");
    ctrl_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && !pwrite && paddr == 8'h00 |=> prdata_ff[31:4] == 28'h0)
        else $error("control readback wider than its fields");
    stat_weight_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && !pwrite && paddr == 8'h0c |=> prdata_ff[12:8] <= 5'd16)
        else $error("comb weight beyond full scale");
    peak_clamp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup && !pwrite && paddr == 8'h04 |=> prdata_ff[15:12] <= 4'h8)
        else $error("peaking above six decibels");
    stall_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_y_ff)
        && $stable(out_c_ff) && $stable(out_is_cr_ff)) else $error("stalled word changed");
    // Reset itself is the cause here, so this one is not disabled by it
    reset_quiet_a: assert property (@(posedge clk_sys)
        !reset_n |=> !out_valid_ff && !pready_ff && !pslverr_ff) else $error("outputs active in reset");
endmodule

bind cfd_comb_demod cfd_props cfd_props_i (.*);

`default_nettype wire

// ### dv/cfd_adc_model.sv
// Behavioural model of the two video converters feeding the demodulator
`timescale 1ns/1ps
`default_nettype none

module cfd_adc_model (
    // Clock
    input wire logic clk_sys,
    // Analog levels asked for by the bench
    input wire logic [7:0] luma_lvl,
    input wire logic [7:0] chroma_lvl,
    // Converted samples
    output var logic [7:0] adc_luma,
    output var logic [7:0] adc_chroma
);
    // Converters sample every clock; one cycle of conversion delay, as a real part has
    always @(posedge clk_sys)
    begin
        adc_luma <= luma_lvl;
        adc_chroma <= chroma_lvl;
    end
endmodule

`default_nettype wire

// ### dv/cfd_comb_demod_tb_top.sv
// Self-checking bench of the comb demodulator: registers, line latency, stream and buffer
`timescale 1ns/1ps
`default_nettype none
`include "cfd_map.vh"

module cfd_comb_demod_tb_top;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] luma_lvl = 8'h20;
    logic [7:0] chroma_lvl = 8'h80;
    logic [7:0] adc_luma;
    logic [7:0] adc_chroma;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic out_ready = 1'b1;
    wire [31:0] prdata_ff;
    wire pready_ff;
    wire pslverr_ff;
    wire out_valid_ff;
    wire [7:0] out_y_ff;
    wire [7:0] out_c_ff;
    wire out_is_cr_ff;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic er;

    cfd_adc_model cfd_adc_model_i (.clk_sys(clk_sys), .luma_lvl(luma_lvl),
        .chroma_lvl(chroma_lvl), .adc_luma(adc_luma), .adc_chroma(adc_chroma));
    cfd_comb_demod cfd_comb_demod_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .adc_luma(adc_luma), .adc_chroma(adc_chroma), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .out_valid_ff(out_valid_ff),
        .out_ready(out_ready), .out_y_ff(out_y_ff), .out_c_ff(out_c_ff),
        .out_is_cr_ff(out_is_cr_ff));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready_ff !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 20)
        begin
            chk(32'h0, 32'h1, "bus answer timeout");
            give_verdict();
        end
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset_values;
        logic [63:0] inc;
        inc = (`CFD_PAL_SC_HZ << 32) / `CFD_FS_HZ;
        apb(1'b0, `CFD_REG_CTRL, 32'h0);
        chk(rd, 32'h1, "control reset");
        apb(1'b0, `CFD_REG_GAIN, 32'h0);
        chk(rd, 32'h00040444, "gain reset");
        apb(1'b0, `CFD_REG_SCINC, 32'h0);
        chk(rd, inc[31:0], "subcarrier increment reset");
        // Comb off first: the weight in STAT is unknown until the line memories fill
        apb(1'b1, `CFD_REG_CTRL, 32'h0);
        apb(1'b0, `CFD_REG_STAT, 32'h0);
        chk({31'h0, rd[0]}, 32'h0, "overflow reset");
    endtask

    task automatic t_fields;
        // Every compensation curve, alternating the fixed-carrier mode
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `CFD_REG_CTRL, 32'hf0 | (i << 1) | ((i & 1) << 3) | 1);
            apb(1'b0, `CFD_REG_CTRL, 32'h0);
            chk(rd, (i << 1) | ((i & 1) << 3) | 1, "control field");
        end
        apb(1'b1, `CFD_REG_GAIN, 32'hffab9321);
        apb(1'b0, `CFD_REG_GAIN, 32'h0);
        chk(rd, 32'h00ab8321, "gain fields, peaking clamp");
        apb(1'b1, `CFD_REG_SCINC, 32'h12345678);
        apb(1'b0, `CFD_REG_SCINC, 32'h0);
        chk(rd, 32'h12345678, "increment readback");
        apb(1'b1, 8'h10, 32'hffffffff);
        chk({31'h0, er}, 32'h1, "unmapped write refused");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped read refused");
    endtask

    task automatic t_latency;
        int n;
        n = 0;
        apb(1'b1, `CFD_REG_CTRL, 32'h0);
        // Line memories must be filled before output data means anything
        repeat (4 * 1280) @(posedge clk_sys);
        chk({24'h0, out_y_ff}, 32'h20, "steady luma through delays");
        luma_lvl <= 8'h90;
        @(posedge clk_sys);
        while (!(out_valid_ff === 1'b1 && out_y_ff === 8'h90) && n < 4000)
        begin
            n++;
            @(posedge clk_sys);
        end
        chk({31'h0, n >= 2 * 1280 && n <= 2 * 1281 + 20}, 32'h1, "two-line latency");
        apb(1'b1, `CFD_REG_CTRL, 32'h1);
        apb(1'b0, `CFD_REG_STAT, 32'h0);
        // Flat picture has no edges: weight is 8 plus the horizontal gain of 1
        chk({27'h0, rd[12:8]}, 32'h9, "comb weight on flat picture");
    endtask

    task automatic t_alternate;
        logic last;
        int got;
        got = 0;
        last = out_is_cr_ff;
        for (int n = 0; n < 100 && got < 16; n++)
        begin
            @(posedge clk_sys);
            if (out_valid_ff === 1'b1 && out_ready)
            begin
                if (got > 0)
                    chk({31'h0, out_is_cr_ff}, {31'h0, ~last}, "cb cr alternate");
                last = out_is_cr_ff;
                got++;
            end
        end
        chk(got, 16, "stream delivers words");
    endtask

    task automatic t_overflow;
        out_ready <= 1'b0;
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `CFD_REG_STAT, 32'h0);
        chk({28'h0, rd[3:0]}, 32'h9, "buffer full and overflow");
        out_ready <= 1'b1;
        repeat (8) @(posedge clk_sys);
        apb(1'b1, `CFD_REG_STAT, 32'h1);
        apb(1'b0, `CFD_REG_STAT, 32'h0);
        chk({31'h0, rd[0]}, 32'h0, "overflow cleared");
    endtask

    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset_values();
        t_fields();
        t_latency();
        t_alternate();
        t_overflow();
        give_verdict();
    end
endmodule

`default_nettype wire
